// File: usb_endpoint_mode_count_logic.sv
// Purpose: Endpoint mode, count, lock and response logic of the serial engine
// Assumes: Serial engine reports tokens, setup start and transaction end
// Notes:   Endpoint 0 is the control endpoint; others are non-control
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module usb_endpoint_mode_count_logic
  import usb_ep_pkg::*;
(
  // System
  input  wire logic        clock,
  input  wire logic        resetn,
  // Avalon-MM slave
  input  wire logic [8:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Serial engine events
  input  wire token_t      token,
  input  wire logic        setup_start,
  input  wire done_t       done,
  // Serial engine answers
  output answer_t          answer,
  output logic [4:0]       ep_event
);

  logic [7:0]          mode_r [EP_COUNT];
  logic [7:0]          count_r [EP_COUNT];
  logic [7:0]          mode_view [EP_COUNT];
  logic [EP_COUNT-1:0] hit_mode;
  logic [EP_COUNT-1:0] hit_count;
  logic [7:0]          idx;
  logic [7:0]          rdata;
  logic                take;
  logic                wr;
  logic                rd;
  logic                setup_flag;
  logic                setup_hold;
  logic                mode_lock;
  logic                count_lock;
  logic                upd;
  logic                upd_d;
  logic                tok_ok;
  logic                acked;
  logic                loaded;
  logic [7:0]          next_mode;
  resp_t               tok_raw;
  resp_t               done_raw;
  resp_t               fin;

  // Bus decode
  assign idx = {1'b0, address[8:2]};
  assign wr  = take & write & byteenable[0];
  assign rd  = take & read;

  usb_ep_bus_slave u_bus (
    .clock       (clock),
    .resetn      (resetn),
    .read        (read),
    .write       (write),
    .waitrequest (waitrequest),
    .readdata    (readdata),
    .rdata       (rdata),
    .take        (take)
  );

  // Endpoint 0 shows the setup flag in place of its stored bit 7
  always_comb begin
    for (int i = 0; i < EP_COUNT; i++) begin
      mode_view[i] = mode_r[i];
    end
    mode_view[0][SETUP_BIT] = setup_flag;
  end

  // Unmapped addresses read as zero and ignore writes
  always_comb begin
    rdata = REG_RESET;
    for (int i = 0; i < EP_COUNT; i++) begin
      if (hit_mode[i]) begin
        rdata = mode_view[i];
      end
      if (hit_count[i]) begin
        rdata = count_r[i];
      end
    end
  end

  // Response decode for token time and for transaction end
  assign tok_ok = token.valid && (token.ep < 3'(EP_COUNT));
  assign upd    = done.valid && (done.ep < 3'(EP_COUNT));

  usb_ep_resp_decode u_tok_dec (
    .mode  (mode_view[token.ep][3:0]),
    .stall (mode_view[token.ep][MODE_STALL_BIT] && token.ep != 3'h0),
    .pid   (token.pid),
    .resp  (tok_raw)
  );

  usb_ep_resp_decode u_done_dec (
    .mode  (mode_view[done.ep][3:0]),
    .stall (mode_view[done.ep][MODE_STALL_BIT] && done.ep != 3'h0),
    .pid   (done.pid),
    .resp  (done_raw)
  );

  // Handshake for SETUP and OUT once the data packet is in
  always_comb begin
    fin = R_IGNORE;
    case (done_raw)
      R_ACK:   fin = done.crc_ok ? R_ACK : R_IGNORE;
      R_CHECK: fin = !done.crc_ok ? R_IGNORE :
                     (done.len == 6'h00 && done.tog) ? R_ACK : R_STALL;
      R_ALWAYS: fin = R_IGNORE;
      default: fin = done_raw;
    endcase
  end

  // IN is acked by the host, SETUP and OUT by us
  always_comb begin
    if (done.pid == P_IN) begin
      acked = done.host_ack && (done_raw == R_TX_COUNT || done_raw == R_TX_ZERO);
    end else begin
      acked = (fin == R_ACK);
    end
  end

  // Buffer is written whenever the endpoint takes the data, good CRC or not
  assign loaded = (done.pid != P_IN) &&
                  (done_raw == R_ACK || done_raw == R_CHECK || done_raw == R_ALWAYS);

  // Mode value written at the update time point
  always_comb begin
    next_mode = mode_view[done.ep];
    if (acked) begin
      next_mode[MODE_ACK_BIT] = 1'b1;
      if (done.pid == P_SETUP) begin
        next_mode[3:0] = M_NAK_IN_OUT;
      end else if (next_mode[3] && next_mode[0]) begin
        next_mode[0] = 1'b0;
      end
    end
    if (done.ep == 3'h0 && done_raw != R_IGNORE) begin
      if (done.pid == P_IN) begin
        next_mode[IN_FLAG_BIT] = 1'b1;
      end
      if (done.pid == P_OUT) begin
        next_mode[OUT_FLAG_BIT] = 1'b1;
      end
    end
  end

  // Register storage, one mode and one count per endpoint
  for (genvar e = 0; e < EP_COUNT; e++) begin : g_ep
    assign hit_mode[e]  = (address[1:0] == 2'h0) && (idx == MODE_IDX[e]);
    assign hit_count[e] = (address[1:0] == 2'h0) && (idx == COUNT_IDX[e]);

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        mode_r[e] <= REG_RESET;
      end else if (upd && done.ep == 3'(e)) begin
        mode_r[e] <= next_mode;
      end else if (wr && hit_mode[e] && !(e == 0 && mode_lock)) begin
        mode_r[e] <= writedata[7:0];
      end
    end

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        count_r[e] <= REG_RESET;
      end else if (upd && done.ep == 3'(e) && loaded) begin
        count_r[e] <= {done.tog, done.crc_ok, 6'(done.len + CRC_BYTES)};
      end else if (wr && hit_count[e] && !(e == 0 && count_lock)) begin
        count_r[e] <= writedata[7:0];
      end
    end
  end

  // Setup flag: set wins, any CPU write to the endpoint 0 mode register clears it outside the hold
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      setup_flag <= 1'b0;
    end else if (setup_start && mode_r[0][3:0] != M_DISABLED) begin
      setup_flag <= 1'b1;
    end else if (wr && hit_mode[0] && !setup_hold) begin
      setup_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      setup_hold <= 1'b0;
    end else if (setup_start && mode_r[0][3:0] != M_DISABLED) begin
      setup_hold <= 1'b1;
    end else if (done.valid && done.pid == P_SETUP) begin
      setup_hold <= 1'b0;
    end
  end

  // Read data was sampled a cycle early; an update then makes it stale
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      upd_d <= 1'b0;
    end else begin
      upd_d <= upd;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_lock <= 1'b0;
    end else if (upd && done.ep == 3'h0 && (acked || loaded)) begin
      mode_lock <= 1'b1;
    end else if (rd && hit_mode[0] && !upd_d) begin
      mode_lock <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_lock <= 1'b0;
    end else if (upd && done.ep == 3'h0 && loaded) begin
      count_lock <= 1'b1;
    end else if (rd && hit_count[0] && !upd_d) begin
      count_lock <= 1'b0;
    end
  end

  // Answers: IN at token time, SETUP and OUT at the end of data
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      answer <= '0;
    end else if (tok_ok && token.pid == P_IN) begin
      answer.valid <= 1'b1;
      answer.resp  <= tok_raw;
      answer.count <= (tok_raw == R_TX_COUNT) ? count_r[token.ep][5:0] : 6'h00;
      answer.tog   <= count_r[token.ep][CNT_TOG_BIT];
    end else if (upd && done.pid != P_IN) begin
      answer.valid <= 1'b1;
      answer.resp  <= fin;
      answer.count <= 6'h00;
      answer.tog   <= 1'b0;
    end else begin
      answer.valid <= 1'b0;
    end
  end

  // Endpoint interrupt flags are raised at the update time point
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ep_event <= 5'h00;
    end else begin
      for (int i = 0; i < EP_COUNT; i++) begin
        ep_event[i] <= upd && done.ep == 3'(i) && (acked || loaded);
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  disabled_ignore_a: assert property (
    tok_ok && token.pid == P_IN && mode_view[token.ep][3:0] == M_DISABLED |=> answer.resp == R_IGNORE)
    else $error("disabled endpoint answered");

  ack_flag_a: assert property (
    upd && done.ep == 3'h1 && acked |=> mode_r[1][MODE_ACK_BIT])
    else $error("ack flag not set");

  stall_in_a: assert property (
    tok_ok && token.ep == 3'h3 && token.pid == P_IN && mode_r[3][MODE_STALL_BIT] && mode_r[3][3:0] == M_ACK_IN
    |=> answer.resp == R_STALL)
    else $error("stalled IN not stalled");

  count_len_a: assert property (
    upd && done.ep == 3'h1 && loaded |=> count_r[1][5:0] == 6'($past(done.len) + CRC_BYTES))
    else $error("count not len plus two");

  dval_tog_a: assert property (
    upd && done.ep == 3'h1 && loaded |=> count_r[1][7:6] == {$past(done.tog), $past(done.crc_ok)})
    else $error("valid or toggle wrong");

  count_lock_a: assert property (
    count_lock && !upd |=> count_r[0] == $past(count_r[0]))
    else $error("locked count changed");

  setup_hold_a: assert property (
    setup_hold |-> setup_flag)
    else $error("setup flag dropped in hold");

  stale_unlock_a: assert property (
    mode_lock && rd && hit_mode[0] && upd_d |=> mode_lock)
    else $error("early read unlocked");

  setup_force_a: assert property (
    upd && done.pid == P_SETUP && done.ep == 3'h0 && acked |=> mode_r[0][3:0] == M_NAK_IN_OUT)
    else $error("setup did not force 0001");

  ack_in_step_a: assert property (
    upd && done.ep == 3'h3 && acked && mode_r[3][3:0] == M_ACK_IN |=> mode_r[3][3:0] == M_NAK_IN)
    else $error("ack in did not step");

  check_out_a: assert property (
    upd && done_raw == R_CHECK && done.crc_ok && done.len != 6'h00 |=> answer.resp == R_STALL)
    else $error("check acked bad packet");

  update_wins_a: assert property (
    upd && done.ep == 3'h1 && wr && hit_mode[1] |=> mode_r[1] == $past(next_mode))
    else $error("write beat update");

  setup_cov: cover property (setup_start ##[1:50] (upd && done.pid == P_SETUP && acked));
  in_tx_cov: cover property (answer.valid && answer.resp == R_TX_COUNT);
  unlock_cov: cover property (mode_lock ##1 !mode_lock);
  bad_crc_cov: cover property (upd && loaded && !done.crc_ok);

endmodule : usb_endpoint_mode_count_logic
`default_nettype wire

// File: usb_endpoint_mode_count_logic_test.sv
// Purpose: Register and response checks of the endpoint mode and count logic
// Assumes: Slave paces every access by waitrequest; answers one cycle after requests
// Notes:   Bus data taken at the accepting edge; engine answers on the falling edge
`timescale 1ns/10ps
`default_nettype none
module usb_endpoint_mode_count_logic_test;
  import usb_ep_pkg::*;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic [8:0]  address = '0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = '0;
  logic [31:0] readdata;
  logic        waitrequest;
  token_t      token;
  logic        setup_start;
  done_t       done;
  answer_t     answer;
  answer_t     a;
  logic [4:0]  ep_event;
  int          n_mismatch = 0;
  int          comparisons = 0;
  localparam resp_t IN_T [16] = '{R_IGNORE, R_NAK, R_STALL, R_STALL, R_IGNORE, R_IGNORE, R_TX_ZERO,
    R_TX_COUNT, R_IGNORE, R_IGNORE, R_TX_ZERO, R_TX_ZERO, R_NAK, R_TX_COUNT, R_NAK, R_TX_COUNT};
  localparam resp_t OUT_T [16] = '{R_IGNORE, R_NAK, R_ACK, R_STALL, R_IGNORE, R_IGNORE, R_STALL,
    R_IGNORE, R_NAK, R_ACK, R_NAK, R_ACK, R_IGNORE, R_IGNORE, R_ACK, R_ACK};

  always #4 clock = ~clock;

  usb_endpoint_mode_count_logic i_dut (
    .clock(clock), .resetn(resetn), .address(address), .read(read), .write(write),
    .byteenable(4'hF), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .token(token), .setup_start(setup_start), .done(done), .answer(answer), .ep_event(ep_event));

  usb_ep_host_model i_host (
    .clock(clock), .answer(answer), .token(token), .setup_start(setup_start), .done(done));

  task automatic conclude();
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clock);
    address   <= {idx[6:0], 2'b00};
    writedata <= {24'h00_0000, d};
    write     <= w;
    read      <= !w;
    @(posedge clock);
    while (waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        n_mismatch++;
        conclude();
      end
      @(posedge clock);
    end
    q = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk($sformatf("reg %h", idx), exp, q);
  endtask : rd

  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    for (int e = 0; e < EP_COUNT; e++) begin
      rd(MODE_IDX[e], REG_RESET);
      rd(COUNT_IDX[e], REG_RESET);
    end
    rd(8'h20, 8'h00);
    // Disabled endpoint
    i_host.send_token(P_IN, 3'd1, a);
    chk("valid", 8'h01, {7'h00, a.valid});
    chk("resp", R_IGNORE, a.resp);
    i_host.send_done(P_OUT, 3'd1, 6'd4, 1'b1, 1'b1, 1'b0, a);
    chk("resp", R_IGNORE, a.resp);
    // Acked OUT then NAK
    wr(8'h14, 8'h09);
    i_host.send_done(P_OUT, 3'd1, 6'd4, 1'b1, 1'b1, 1'b0, a);
    chk("resp", R_ACK, a.resp);
    chk("event", 8'h02, {3'b000, ep_event});
    rd(8'h14, 8'h18);
    rd(8'h13, 8'hC6);
    wr(8'h13, 8'h07);
    rd(8'h13, 8'h07);
    i_host.send_done(P_OUT, 3'd1, 6'd4, 1'b1, 1'b1, 1'b0, a);
    chk("resp", R_NAK, a.resp);
    // Bad CRC at the largest packet still interrupts
    wr(8'h14, 8'h09);
    i_host.send_done(P_OUT, 3'd1, 6'd32, 1'b0, 1'b0, 1'b0, a);
    chk("event", 8'h02, {3'b000, ep_event});
    rd(8'h13, 8'h22);
    rd(8'h14, 8'h09);
    // Update and CPU write land on the same edge
    fork
      wr(8'h14, 8'h0D);
      begin
        @(posedge clock);
        i_host.send_done(P_OUT, 3'h1, 6'h00, 1'b1, 1'b0, 1'b0, a);
      end
    join
    chk("resp", R_ACK, a.resp);
    rd(8'h14, 8'h18);
    // Stalled OUT
    wr(8'h16, 8'h89);
    i_host.send_done(P_OUT, 3'd2, 6'd1, 1'b1, 1'b0, 1'b0, a);
    chk("resp", R_STALL, a.resp);
    // IN with full count, then NAK, then stall
    wr(8'h41, 8'hA0);
    wr(8'h42, 8'h0D);
    i_host.send_token(P_IN, 3'd3, a);
    chk("resp", R_TX_COUNT, a.resp);
    chk("count", 8'h20, {2'b00, a.count});
    chk("tog", 8'h01, {7'h00, a.tog});
    i_host.send_done(P_IN, 3'd3, 6'd0, 1'b1, 1'b0, 1'b1, a);
    rd(8'h42, 8'h1C);
    i_host.send_token(P_IN, 3'd3, a);
    chk("resp", R_NAK, a.resp);
    wr(8'h42, 8'h8D);
    i_host.send_token(P_IN, 3'd3, a);
    chk("resp", R_STALL, a.resp);
    // Every mode against IN and a zero-length DATA1 OUT
    for (int m = 0; m < 16; m++) begin
      wr(8'h44, {4'h0, m[3:0]});
      i_host.send_token(P_IN, 3'd4, a);
      chk($sformatf("in %0d", m), IN_T[m], a.resp);
      i_host.send_done(P_OUT, 3'd4, 6'd0, 1'b1, 1'b1, 1'b0, a);
      chk($sformatf("out %0d", m), OUT_T[m], a.resp);
    end
    wr(8'h44, 8'h0F);
    i_host.send_done(P_OUT, 3'd4, 6'd3, 1'b1, 1'b1, 1'b0, a);
    chk("resp", R_STALL, a.resp);
    // Setup on the control endpoint
    wr(8'h12, 8'h02);
    i_host.pulse_setup();
    rd(8'h12, 8'h82);
    wr(8'h12, 8'h02);
    rd(8'h12, 8'h82);
    i_host.send_done(P_SETUP, 3'd0, 6'd8, 1'b1, 1'b0, 1'b0, a);
    chk("resp", R_ACK, a.resp);
    wr(8'h11, 8'h00);
    rd(8'h11, 8'h4A);
    wr(8'h11, 8'h05);
    rd(8'h11, 8'h05);
    rd(8'h12, 8'h91);
    // Read overlapping the update sees stale data and keeps the lock
    wr(8'h12, 8'h0B);
    fork
      rd(8'h12, 8'h0B);
      i_host.send_done(P_OUT, 3'h0, 6'h00, 1'b1, 1'b1, 1'b0, a);
    join
    chk("resp", R_ACK, a.resp);
    wr(8'h12, 8'h01);
    rd(8'h12, 8'h3A);
    rd(8'h11, 8'hC2);
    conclude();
  end
endmodule : usb_endpoint_mode_count_logic_test
`default_nettype wire

// File: usb_ep_bus_slave.sv
// Purpose: Avalon-MM handshake with one wait state per access
// Assumes: Master holds the request until waitrequest is low
// Notes:   Read data is loaded in the wait cycle
`timescale 1ns/10ps
`default_nettype none
module usb_ep_bus_slave (
  // System
  input  wire logic        clock,
  input  wire logic        resetn,
  // Bus side
  input  wire logic        read,
  input  wire logic        write,
  output logic             waitrequest,
  output logic [31:0]      readdata,
  // Register side
  input  wire logic [7:0]  rdata,
  output logic             take
);

  logic pend;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pend <= 1'b0;
    end else begin
      pend <= (read | write) & ~pend;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      readdata <= 32'h0000_0000;
    end else if (read & ~pend) begin
      readdata <= {24'h00_0000, rdata};
    end
  end

  // Fixed latency keeps the lock timing simple to reason about
  assign waitrequest = (read | write) & ~pend;
  assign take        = (read | write) & pend;

endmodule : usb_ep_bus_slave
`default_nettype wire

// File: usb_ep_host_model.sv
// Purpose: Host side model issuing tokens, setup starts and transaction ends
// Assumes: Engine answers are registered, one cycle after each request
// Notes:   Idle fields are inverted so a stale value never reads as fresh
`timescale 1ns/10ps
`default_nettype none
module usb_ep_host_model
  import usb_ep_pkg::*;
(
  // System
  input  wire logic    clock,
  // Engine side
  input  wire answer_t answer,
  output token_t       token,
  output logic         setup_start,
  output done_t        done
);
  initial begin
    token       = '0;
    setup_start = 1'b0;
    done        = '0;
  end

  task automatic send_token(input pid_t p, input logic [2:0] e, output answer_t a);
    @(posedge clock);
    token <= '{valid: 1'b1, pid: p, ep: e};
    @(posedge clock);
    token <= {1'b0, ~token[4:0]};
    @(negedge clock);
    a = answer;
  endtask : send_token

  task automatic send_done(input pid_t p, input logic [2:0] e, input logic [5:0] n,
                           input logic c, input logic t, input logic h, output answer_t a);
    @(posedge clock);
    done <= '{valid: 1'b1, pid: p, ep: e, len: n, crc_ok: c, tog: t, host_ack: h};
    @(posedge clock);
    done <= {1'b0, ~done[13:0]};
    @(negedge clock);
    a = answer;
  endtask : send_done

  task automatic pulse_setup();
    @(posedge clock);
    setup_start <= 1'b1;
    @(posedge clock);
    setup_start <= 1'b0;
  endtask : pulse_setup
endmodule : usb_ep_host_model
`default_nettype wire

// File: usb_ep_pkg.sv
// Purpose: Shared constants and types for the endpoint mode/count logic
// Assumes: Byte-wide registers, one per aligned 32-bit bus word
// Notes:   Byte address is four times the register index
package usb_ep_pkg;

  localparam int EP_COUNT = 5;

  // Register indices, byte address = index * 4
  localparam logic [4:0][7:0] MODE_IDX  = {8'h44, 8'h42, 8'h16, 8'h14, 8'h12};
  localparam logic [4:0][7:0] COUNT_IDX = {8'h45, 8'h41, 8'h15, 8'h13, 8'h11};
  localparam logic [7:0]      REG_RESET = 8'h00;

  // Mode register fields
  localparam int MODE_STALL_BIT = 7;
  localparam int SETUP_BIT      = 7;
  localparam int IN_FLAG_BIT    = 6;
  localparam int OUT_FLAG_BIT   = 5;
  localparam int MODE_ACK_BIT   = 4;

  // Count register fields
  localparam int         CNT_TOG_BIT  = 7;
  localparam int         CNT_DVAL_BIT = 6;
  localparam logic [5:0] CRC_BYTES    = 6'h02;

  // Mode encodings
  localparam logic [3:0] M_DISABLED      = 4'h0;
  localparam logic [3:0] M_NAK_IN_OUT    = 4'h1;
  localparam logic [3:0] M_STATUS_OUT    = 4'h2;
  localparam logic [3:0] M_STALL_IN_OUT  = 4'h3;
  localparam logic [3:0] M_IGNORE_IN_OUT = 4'h4;
  localparam logic [3:0] M_ISO_OUT       = 4'h5;
  localparam logic [3:0] M_STATUS_IN     = 4'h6;
  localparam logic [3:0] M_ISO_IN        = 4'h7;
  localparam logic [3:0] M_NAK_OUT       = 4'h8;
  localparam logic [3:0] M_ACK_OUT       = 4'h9;
  localparam logic [3:0] M_NAK_OUT_STIN  = 4'hA;
  localparam logic [3:0] M_ACK_OUT_STIN  = 4'hB;
  localparam logic [3:0] M_NAK_IN        = 4'hC;
  localparam logic [3:0] M_ACK_IN        = 4'hD;
  localparam logic [3:0] M_NAK_IN_STOUT  = 4'hE;
  localparam logic [3:0] M_ACK_IN_STOUT  = 4'hF;

  typedef enum logic [1:0] {P_SETUP, P_IN, P_OUT} pid_t;
  typedef enum logic [2:0] {R_IGNORE, R_NAK, R_ACK, R_STALL, R_TX_COUNT, R_TX_ZERO, R_CHECK, R_ALWAYS} resp_t;

  typedef struct packed {
    logic       valid;
    pid_t       pid;
    logic [2:0] ep;
  } token_t;

  typedef struct packed {
    logic       valid;
    pid_t       pid;
    logic [2:0] ep;
    logic [5:0] len;
    logic       crc_ok;
    logic       tog;
    logic       host_ack;
  } done_t;

  typedef struct packed {
    logic       valid;
    resp_t      resp;
    logic [5:0] count;
    logic       tog;
  } answer_t;

endpackage : usb_ep_pkg

// File: usb_ep_resp_decode.sv
// Purpose: Raw response of one endpoint to one token kind
// Assumes: Mode and stall come from the mode register; stall is held low for endpoint 0
// Notes:   Check and accept are resolved later against CRC and length
`timescale 1ns/10ps
`default_nettype none
module usb_ep_resp_decode
  import usb_ep_pkg::*;
(
  // Endpoint state
  input  wire logic [3:0] mode,
  input  wire logic       stall,
  // Token
  input  wire pid_t       pid,
  // Answer
  output resp_t           resp
);

  always_comb begin
    resp = R_IGNORE;
    case (mode)
      M_DISABLED:      resp = R_IGNORE;
      M_NAK_IN_OUT:    resp = (pid == P_SETUP) ? R_ACK : R_NAK;
      M_STATUS_OUT:    resp = (pid == P_SETUP) ? R_ACK : (pid == P_IN) ? R_STALL : R_CHECK;
      M_STALL_IN_OUT:  resp = (pid == P_SETUP) ? R_ACK : R_STALL;
      M_IGNORE_IN_OUT: resp = (pid == P_SETUP) ? R_ACK : R_IGNORE;
      M_ISO_OUT:       resp = (pid == P_OUT) ? R_ALWAYS : R_IGNORE;
      M_STATUS_IN:     resp = (pid == P_SETUP) ? R_ACK : (pid == P_IN) ? R_TX_ZERO : R_STALL;
      M_ISO_IN:        resp = (pid == P_IN) ? R_TX_COUNT : R_IGNORE;
      M_NAK_OUT:       resp = (pid == P_OUT) ? R_NAK : R_IGNORE;
      M_ACK_OUT:       resp = (pid != P_OUT) ? R_IGNORE : stall ? R_STALL : R_ACK;
      M_NAK_OUT_STIN:  resp = (pid == P_SETUP) ? R_ACK : (pid == P_IN) ? R_TX_ZERO : R_NAK;
      M_ACK_OUT_STIN:  resp = (pid == P_IN) ? R_TX_ZERO : R_ACK;
      M_NAK_IN:        resp = (pid == P_IN) ? R_NAK : R_IGNORE;
      M_ACK_IN:        resp = (pid != P_IN) ? R_IGNORE : stall ? R_STALL : R_TX_COUNT;
      M_NAK_IN_STOUT:  resp = (pid == P_SETUP) ? R_ACK : (pid == P_IN) ? R_NAK : R_CHECK;
      M_ACK_IN_STOUT:  resp = (pid == P_SETUP) ? R_ACK : (pid == P_IN) ? R_TX_COUNT : R_CHECK;
      default:         resp = R_IGNORE;
    endcase
  end

endmodule : usb_ep_resp_decode
`default_nettype wire
